/* File: reb_pkg.sv */
// Purpose: Shared constants for the resonant edge and burst timing slice
// Assumes: 100 MHz clock, 5 ns timing steps, AXI4-Lite register access
// Notes:   Printed offsets are register indexes; byte address is 4x
package reb_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register indexes and byte addresses
  localparam logic [9:0] IDX_FREQ_HI = 10'h046; // Min cycle, upper 8 bits
  localparam logic [9:0] IDX_FREQ_LO = 10'h048; // Min cycle, low nibble
  localparam logic [9:0] IDX_RISE = 10'h049; // Third output rise offset
  localparam logic [9:0] IDX_BURST = 10'h04a; // Burst control
  localparam logic [9:0] IDX_STATUS = 10'h080; // Live state readback
  localparam logic [11:0] ADDR_FREQ_HI = {IDX_FREQ_HI, 2'b00};
  localparam logic [11:0] ADDR_FREQ_LO = {IDX_FREQ_LO, 2'b00};
  localparam logic [11:0] ADDR_RISE = {IDX_RISE, 2'b00};
  localparam logic [11:0] ADDR_BURST = {IDX_BURST, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_FREQ_HI = 8'h00;
  localparam logic [7:0] RST_FREQ_LO = 8'h00;
  localparam logic [7:0] RST_RISE = 8'h00;
  localparam logic [7:0] RST_BURST = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FREQ_LO_MSB = 7; // Low nibble of min cycle
  localparam int FREQ_LO_LSB = 4;
  localparam int BURST_EN_MSB = 7; // Burst enable field
  localparam int BURST_EN_LSB = 6;
  localparam int BURST_OFS_MSB = 5; // Burst offset field
  localparam int BURST_OFS_LSB = 0;
  localparam int BURST_OFS_SHIFT = 4; // Offset weight against min cycle
  ////////////////////////////////////////////////////////////////////////////
  // Burst enable encodings
  typedef enum logic [1:0] {
    BURST_OFF0 = 2'b00,
    BURST_NORMAL = 2'b01,
    BURST_OFF1 = 2'b10,
    BURST_ALWAYS = 2'b11
  } reb_burst_t;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int STEP_PS = 5000; // One setting step, 5 ns
  localparam int CLK_PS = 10000; // Clock period, 10 ns
  localparam logic [13:0] UNITS_PER_CLK = 14'(CLK_PS / STEP_PS);
  localparam logic [8:0] RANGE_WRAP = 9'h100; // Upper-half base of 256
  ////////////////////////////////////////////////////////////////////////////
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : reb_pkg

/* File: reb_edge_place.sv */
// Purpose: Rising-edge position of the third gate output within a cycle
// Assumes: Period and setting are stable between cycle boundaries
// Notes:   Result is in 5 ns units, clamped into the cycle
`timescale 1ns/1ps
module reb_edge_place (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] period, // Active cycle length, 5 ns units
  input wire logic [7:0] setting, // Rise offset setting
  output logic [13:0] risePos // Rise point from cycle start
);
  import reb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Signed position arithmetic, one spare bit against overflow
  logic signed [14:0] midPoint; // Cycle midpoint
  logic signed [14:0] shift; // Signed offset in steps
  logic signed [14:0] rawPos; // Unclamped rise point

  // Decode the setting: low half trails, high half leads the midpoint
  always_comb begin
    midPoint = 15'(period >> 1);
    if (!setting[7]) begin
      shift = 15'(setting);
    end else begin
      shift = -15'(RANGE_WRAP - 9'(setting));
    end
    rawPos = midPoint + shift;
  end

  // Clamp into the cycle so an oversized lead cannot wrap round
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      risePos <= 14'h0000;
    end else if (rawPos < 0) begin
      risePos <= 14'h0000;
    end else if (rawPos > 15'(period)) begin
      risePos <= 14'(period);
    end else begin
      risePos <= 14'(rawPos);
    end
  end

  a_trail_place: assert property (@(posedge clk) disable iff (!reset_n)
    !setting[7] && 15'(period >> 1) + 15'(setting) <= 15'(period)
    |=> risePos == 14'($past(period) >> 1) + 14'($past(setting)))
    else $error("Trailing rise point wrong");
  a_lead_place: assert property (@(posedge clk) disable iff (!reset_n)
    setting[7] && 15'(period >> 1) >= 15'(RANGE_WRAP - 9'(setting))
    |=> risePos == 14'($past(period) >> 1)
        - 14'(RANGE_WRAP - 9'($past(setting))))
    else $error("Leading rise point wrong");
endmodule : reb_edge_place

/* File: reb_resonant_edge_burst_ctrl.sv */
// Purpose: Resonant third-output rise placement and burst-mode control
// Assumes: loopPeriod and softStart come from logic on the same clock
// Notes:   Registers over AXI4-Lite; settings take effect per cycle
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module reb_resonant_edge_burst_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] loopPeriod, // Requested cycle, 5 ns units
  input wire logic softStart, // High while soft start runs
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic third_gate_output, // Gate drive of the third switch
  output logic burstActive, // Burst mode holding the stage off
  output logic cycleStart // Pulse on first clock of each cycle
);
  import reb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0] freqHi; // Min cycle upper byte
  logic [7:0] freqLo; // Min cycle low nibble in top bits
  logic [7:0] third_rise_offset; // Rise offset setting
  logic [7:0] burstCtrl; // Burst enable and offset
  // Bus holding state
  logic [11:0] awAddr; // Captured write address
  logic awHeld; // Write address waiting
  logic [31:0] wData; // Captured write data
  logic [3:0] wStrb; // Captured strobes
  logic wHeld; // Write data waiting
  // Cycle-boundary shadows
  logic [11:0] activePeriod; // Period used by the running cycle
  logic [7:0] liveRise; // Rise setting used by the running cycle
  logic [13:0] pos; // Position in cycle, 5 ns units
  logic [13:0] risePos; // Rise point from placement unit
  logic cycleEnd; // Last clock of the cycle

  // Known address test, used by the write response path only
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == ADDR_FREQ_HI) || (a == ADDR_FREQ_LO) ||
               (a == ADDR_RISE) || (a == ADDR_BURST);
  endfunction : isMapped

  // Twelve-bit minimum cycle from the two limit registers
  function automatic logic [11:0] minCycle(input logic [7:0] hi,
                                           input logic [7:0] lo);
    minCycle = {hi, lo[FREQ_LO_MSB:FREQ_LO_LSB]};
  endfunction : minCycle

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture; address and data may come in either order
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (awHeld && wHeld && !s_axi_bvalid) begin
      awHeld <= 1'b0; // Consumed by the write
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (awHeld && wHeld && !s_axi_bvalid) begin
      wHeld <= 1'b0;
    end
  end

  // Ready is registered and drops once a beat is held
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Response once both halves are held; unmapped gives SLVERR
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (awHeld && wHeld && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register store; only byte lane 0 carries data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      freqHi <= RST_FREQ_HI;
      freqLo <= RST_FREQ_LO;
      third_rise_offset <= RST_RISE;
      burstCtrl <= RST_BURST;
    end else if (awHeld && wHeld && !s_axi_bvalid && wStrb[0]) begin
      case (awAddr)
        ADDR_FREQ_HI: freqHi <= wData[7:0];
        ADDR_FREQ_LO: freqLo <= wData[7:0];
        ADDR_RISE: third_rise_offset <= wData[7:0];
        ADDR_BURST: burstCtrl <= wData[7:0];
        default: ; // Unmapped, nothing stored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read in flight, data registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_FREQ_HI: s_axi_rdata <= {24'h000000, freqHi};
        ADDR_FREQ_LO: s_axi_rdata <= {24'h000000, freqLo};
        ADDR_RISE: s_axi_rdata <= {24'h000000, third_rise_offset};
        ADDR_BURST: s_axi_rdata <= {24'h000000, burstCtrl};
        ADDR_STATUS: s_axi_rdata <= {16'h0000, burstActive,
                                     third_gate_output, 2'b00,
                                     activePeriod};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timebase; counts 5 ns units, two per clock
  assign cycleEnd = (pos + UNITS_PER_CLK) >= 14'(activePeriod);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pos <= 14'h0000;
      cycleStart <= 1'b0;
    end else if (cycleEnd) begin
      pos <= 14'h0000;
      cycleStart <= 1'b1;
    end else begin
      pos <= pos + UNITS_PER_CLK;
      cycleStart <= 1'b0;
    end
  end

  // Period of the coming cycle; the frequency ceiling clamps the request
  logic [11:0] nextPeriod; // Period loaded at the next wrap
  assign nextPeriod = (loopPeriod < minCycle(freqHi, freqLo)) ?
                      minCycle(freqHi, freqLo) : loopPeriod;

  // Shadows load only at the wrap so a cycle never mixes settings
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      activePeriod <= 12'h000;
      liveRise <= RST_RISE;
    end else if (cycleEnd) begin
      liveRise <= third_rise_offset;
      activePeriod <= nextPeriod;
    end
  end

  // At the wrap the placement unit already sees the coming cycle's values,
  // so the first clock of a cycle never compares against a stale rise point
  logic [11:0] placePeriod; // Period fed to placement
  logic [7:0] placeRise; // Setting fed to placement
  assign placePeriod = cycleEnd ? nextPeriod : activePeriod;
  assign placeRise = cycleEnd ? third_rise_offset : liveRise;

  // Placement unit sees only values of the running or coming cycle
  reb_edge_place u_place (
    .clk(clk),
    .reset_n(reset_n),
    .period(placePeriod),
    .setting(placeRise),
    .risePos(risePos)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Burst decision, re-taken at each boundary
  logic burstAllowed; // Enable field against soft-start state
  logic [12:0] burstThresh; // Entry threshold, 5 ns units
  always_comb begin
    case (reb_burst_t'(burstCtrl[BURST_EN_MSB:BURST_EN_LSB]))
      BURST_NORMAL: burstAllowed = !softStart;
      BURST_ALWAYS: burstAllowed = 1'b1;
      default: burstAllowed = 1'b0;
    endcase
    burstThresh = 13'(minCycle(freqHi, freqLo)) +
      13'({burstCtrl[BURST_OFS_MSB:BURST_OFS_LSB], 4'h0});
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      burstActive <= 1'b0;
    end else if (cycleEnd) begin
      // Short requested cycle means light load: skip pulses
      burstActive <= burstAllowed && (13'(loopPeriod) <= burstThresh);
    end
  end

  // Gate rises at the placed point, falls at the wrap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      third_gate_output <= 1'b0;
    end else if (cycleEnd || burstActive) begin
      third_gate_output <= 1'b0;
    end else begin
      third_gate_output <= pos >= risePos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_shadow_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(cycleEnd) |-> $stable(liveRise) && $stable(activePeriod))
    else $error("Setting changed inside a cycle");
  a_burst_off: assert property (@(posedge clk) disable iff (!reset_n)
    cycleEnd && !burstCtrl[BURST_EN_LSB] |=> !burstActive)
    else $error("Burst entered while disabled");
  a_burst_soft: assert property (@(posedge clk) disable iff (!reset_n)
    cycleEnd && softStart && burstCtrl[7:6] == BURST_NORMAL
    |=> !burstActive)
    else $error("Burst entered during soft start");
  a_burst_enter: assert property (@(posedge clk) disable iff (!reset_n)
    cycleEnd && burstCtrl[7:6] == BURST_ALWAYS &&
    13'(loopPeriod) <= burstThresh |=> burstActive)
    else $error("Burst not entered below threshold");
  a_min_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    cycleEnd |=> activePeriod >= {$past(freqHi), $past(freqLo[7:4])})
    else $error("Cycle shorter than limit");
  a_step_rate: assert property (@(posedge clk) disable iff (!reset_n)
    !cycleEnd |=> pos == $past(pos) + 14'd2)
    else $error("Timebase not 5 ns per unit");
  a_gate_rise: assert property (@(posedge clk) disable iff (!reset_n)
    !cycleEnd && !burstActive && pos >= risePos
    |=> third_gate_output)
    else $error("Gate missed its rise point");
  a_gate_early: assert property (@(posedge clk) disable iff (!reset_n)
    pos < risePos |=> !third_gate_output)
    else $error("Gate rose before its point");
endmodule : reb_resonant_edge_burst_ctrl

/* File: reb_power_stage.sv */
// Purpose: Behavioural power stage switch behind the third gate drive
// Assumes: Gate drive high turns the switch on, same clock as the block
// Notes:   Counts turn-on events so the bench can see skipped pulses
`timescale 1ns/1ps
module reb_power_stage (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic gateDrive, // Gate drive from the block
  output logic switchOn, // Switch conducting
  output logic [15:0] onCount // Turn-on events since reset
);
  ////////////////////////////////////////////////////////////////////////////
  // Switch follows the gate one clock late, like a real driver delay
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      switchOn <= 1'b0;
      onCount <= 16'h0000;
    end else begin
      switchOn <= gateDrive;
      // Count only fresh turn-ons, not a held gate
      if (gateDrive && !switchOn) begin
        onCount <= onCount + 16'h0001;
      end
    end
  end
endmodule : reb_power_stage

/* File: resonant_edge_burst_ctrl_tb.sv */
// Purpose: Self-checking bench for the rise placement and burst slice
// Assumes: AXI4-Lite master tasks, 100 MHz clock, 600-unit loop period
// Notes:   Expected edge clocks are worked out from the 5 ns step scale
`timescale 1ns/1ps
module resonant_edge_burst_ctrl_tb;
  import reb_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] loopPeriod = 12'h258; // 600 units, 300 clocks a cycle
  logic softStart = 1'b0;
  logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h00000000;
  logic [3:0] wStrb = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic third_gate_output, burstActive, cycleStart, switchOn;
  logic [15:0] onCount;
  int err_total = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  reb_resonant_edge_burst_ctrl DUT (.clk(clk), .reset_n(reset_n),
    .loopPeriod(loopPeriod), .softStart(softStart),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .third_gate_output(third_gate_output), .burstActive(burstActive),
    .cycleStart(cycleStart));
  // Far-side switch model
  reb_power_stage stage (.clk(clk), .reset_n(reset_n),
    .gateDrive(third_gate_output), .switchOn(switchOn), .onCount(onCount));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run end, single exit point
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic timed_out;
    err_total++;
    end_of_test();
  endtask : timed_out
  // Case inequality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] st, output logic [1:0] resp);
    int n;
    @(posedge clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wStrb <= st;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    if (n == 100) timed_out();
    resp = bResp;
    bReady <= 1'b0;
  endtask : axi_write
  // Read: rready held from the start until rvalid is sampled
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    if (n == 100) timed_out();
    d = rData;
    resp = rResp;
    rReady <= 1'b0;
  endtask : axi_read
  ////////////////////////////////////////////////////////////////////////////
  // Cycle timing helpers, bounded by the longest legal cycle
  task automatic wait_start;
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (cycleStart === 1'b1) break;
    end
    if (n == 3000) timed_out();
  endtask : wait_start
  // Edges from cycle start to gate high, and to the next start
  task automatic measure(output int rise, output int cyc);
    int n;
    rise = -1;
    wait_start();
    for (n = 1; n < 3000; n++) begin
      @(posedge clk);
      if (rise < 0 && third_gate_output === 1'b1) rise = n;
      if (cycleStart === 1'b1) break;
    end
    if (n == 3000) timed_out();
    cyc = n;
  endtask : measure
  // Burst setting held two boundaries, then one whole cycle observed
  task automatic burst_case(input logic [7:0] val, input logic ss,
                            input logic expb);
    logic [15:0] c0;
    logic [1:0] r;
    axi_write(ADDR_BURST, {24'h000000, val}, 4'h1, r);
    softStart <= ss;
    wait_start();
    wait_start();
    c0 = onCount;
    wait_start();
    chk("burst active", {31'h0, burstActive}, {31'h0, expb});
    chk("turn-ons", 32'(onCount - c0), expb ? 32'h0 : 32'h1);
  endtask : burst_case
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] set [6];
    logic [11:0] regs [4];
    int rise, cyc, rp, k;
    set = '{8'h00, 8'h01, 8'h14, 8'h7f, 8'h80, 8'hfe};
    regs = '{ADDR_FREQ_HI, ADDR_FREQ_LO, ADDR_RISE, ADDR_BURST};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values of all settings
    foreach (regs[i]) begin
      axi_read(regs[i], d, r);
      chk("reset value", d, 32'h00000000);
    end
    // Unmapped place refuses with slave error and reads zero
    axi_read(12'h300, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", d, 32'h00000000);
    axi_write(12'h300, 32'h00000055, 4'hf, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    // Eight-bit width, and a cleared low strobe stores nothing
    axi_write(ADDR_RISE, 32'hffffff14, 4'hf, r);
    chk("write bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    axi_write(ADDR_RISE, 32'h00000033, 4'he, r);
    axi_read(ADDR_RISE, d, r);
    chk("rise readback", d, 32'h00000014);
    axi_write(ADDR_RISE, 32'h00000000, 4'h1, r);
    // Minimum cycle of 0x409 units overrides the 600-unit request
    wait_start();
    axi_write(ADDR_FREQ_HI, 32'h00000040, 4'h1, r);
    axi_write(ADDR_FREQ_LO, 32'h0000009f, 4'h1, r);
    axi_read(ADDR_STATUS, d, r);
    chk("period mid-cycle", {20'h0, d[11:0]}, 32'h00000258);
    wait_start();
    axi_read(ADDR_STATUS, d, r);
    chk("min period", {20'h0, d[11:0]}, 32'h00000409);
    axi_read(ADDR_FREQ_LO, d, r);
    chk("low nibble reg", d, 32'h0000009f);
    measure(rise, cyc);
    chk("long cycle", cyc, 32'd517);
    chk("long cycle rise", rise, 32'd259);
    // Back to a 32-unit floor so the 600-unit request rules
    axi_write(ADDR_FREQ_HI, 32'h00000002, 4'h1, r);
    axi_write(ADDR_FREQ_LO, 32'h00000000, 4'h1, r);
    // Rise table: boundaries of both halves around the midpoint
    foreach (set[i]) begin
      axi_write(ADDR_RISE, {24'h000000, set[i]}, 4'h1, r);
      wait_start();
      wait_start();
      measure(rise, cyc);
      rp = set[i][7] ? 300 - (256 - set[i]) : 300 + set[i];
      chk("rise edge", rise, (rp + 1) / 2 + 1);
      chk("cycle length", cyc, 32'd300);
    end
    axi_write(ADDR_RISE, 32'h00000000, 4'h1, r);
    // Threshold 32+35*16 stays under 600; every enable code at 32+36*16
    burst_case({2'b11, 6'h23}, 1'b0, 1'b0);
    for (k = 0; k < 8; k++) begin
      burst_case({k[1:0], 6'h24}, k[2],
        k[1:0] == 2'b11 || (k[1:0] == 2'b01 && !k[2]));
    end
    end_of_test();
  end
endmodule : resonant_edge_burst_ctrl_tb
